// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`include "tpw_defs.svh"
module tb_top;
	import tpw_pkg::*;
	logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
	logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pad_a, pad_b;
	logic [1:0] htrans;
	logic [2:0] hsize;
	tpw_bus_t haddr, hwdata, hrdata, rdv;
	int n_fail, comparisons, hi, per, k, n;
	tpw_mode_t md [7] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'h8, 4'h9};
	tpw_word_t top [7] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0040,
		16'h0040, 16'h0040, 16'h0040};
	int dv [5] = '{1, 8, 64, 256, 1024};

	tpw_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_a_out(pin_a_out),
		.pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
		.irq(irq));
	tpw_load LOAD (.sys_clk(sys_clk), .pin_a_out(pin_a_out),
		.pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
		.pad_a(pad_a), .pad_b(pad_b));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task chk(input tpw_bus_t got, input tpw_bus_t exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s: got %h, expected %h", $time, m, got, exp);
		end
	endtask

	task stuck(input string m);
		n_fail++;
		$display("BAD %0t %s: no answer", $time, m);
		tally_and_finish();
	endtask

	// Hold until hready is high at a falling edge; data taken there
	task wait_ready(input string m);
		int i;
		i = 0;
		@(negedge sys_clk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 100) stuck(m);
			@(negedge sys_clk);
		end
		rdv = hrdata;
		@(posedge sys_clk);
	endtask

	task bus(input logic w, input logic [7:0] a, input tpw_bus_t d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready("address phase");
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= d;
		wait_ready("data phase");
	endtask

	task rd(input logic [7:0] a, input tpw_bus_t exp, input string m);
		bus(1'b0, a, 32'h00000000);
		chk(rdv, exp, m);
	endtask

	task cfg(input tpw_bus_t ctrl, input tpw_word_t cap, input tpw_word_t ca,
		input tpw_word_t cb);
		bus(1'b1, `TPW_OFF_CTRL, 32'h00000000);
		bus(1'b1, `TPW_OFF_CAPT, {16'h0000, cap});
		bus(1'b1, `TPW_OFF_CMPA, {16'h0000, ca});
		bus(1'b1, `TPW_OFF_CMPB, {16'h0000, cb});
		bus(1'b1, `TPW_OFF_CNT, 32'h00000000);
		bus(1'b1, `TPW_OFF_CTRL, ctrl);
	endtask

	// High time and period of pad B, from one rise to the next
	task measure;
		int i;
		i = 0;
		hi = 0;
		per = 0;
		while (pad_b !== 1'b0 || pin_b_oe !== 1'b1 || i == 0) begin
			@(negedge sys_clk);
			i++;
			if (i > 20000) stuck("pwm low");
		end
		while (pad_b !== 1'b1) begin
			@(negedge sys_clk);
			i++;
			if (i > 20000) stuck("pwm rise");
		end
		while (pad_b === 1'b1) begin
			@(negedge sys_clk);
			hi++;
			per++;
			if (per > 20000) stuck("pwm high");
		end
		while (pad_b === 1'b0) begin
			@(negedge sys_clk);
			per++;
			if (per > 20000) stuck("pwm period");
		end
		@(posedge sys_clk);
	endtask

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		n_fail = 0;
		comparisons = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(`TPW_OFF_CTRL, 32'h00000000, "ctrl reset");
		rd(`TPW_OFF_CNT, 32'h00000000, "counter reset");
		rd(`TPW_OFF_STAT, 32'h00000000, "status reset");
		rd(8'h1c, 32'h00000000, "unmapped read");
		chk({31'h0, hresp}, 32'h00000000, "response");
		$display("Test reset done");
		bus(1'b1, `TPW_OFF_CTRL, 32'h00000001);
		bus(1'b1, `TPW_OFF_CMPA, 32'h00001234);
		rd(`TPW_OFF_CMPA, 32'h00000034, "mask 8 bit");
		bus(1'b1, `TPW_OFF_CTRL, 32'h00000003);
		bus(1'b1, `TPW_OFF_CMPB, 32'h0000ffff);
		rd(`TPW_OFF_CMPB, 32'h000003ff, "mask 10 bit");
		$display("Test masking done");
		// Every tops stay at or above 3, above compare B and at or above compare A
		for (k = 0; k < 7; k++) begin
			cfg({28'h0, md[k]} | (k % 2 ? 32'hc0 : 32'h80) | 32'h2100,
				16'h0040, top[k], 16'h0010);
			measure();
			bus(1'b0, `TPW_OFF_STAT, 32'h00000000);
			measure();
			chk(per, 2 * top[k], "pwm period");
			chk(hi, k % 2 ? 2 * top[k] - 32 : 32, "pwm high");
			rd(`TPW_OFF_STAT, (md[k] == 4'ha || md[k] == 4'h8) ? 32'hf : 32'h7,
				"flags");
		end
		$display("Test modes done");
		for (k = 0; k < 5; k++) begin
			cfg({21'h0, 3'(k + 1), 8'h8a} | 32'h2000, 16'h0003, 16'h0003,
				16'h0001);
			measure();
			chk(per, 6 * dv[k], "prescaled period");
			chk(hi, 2 * dv[k], "prescaled high");
		end
		$display("Test prescaler done");
		for (k = 0; k < 3; k++) begin
			cfg(k == 2 ? 32'h31e1 : 32'h31a1, 16'h0040, 16'h00ff,
				k == 1 ? 16'h00ff : 16'h0000);
			repeat (600) @(posedge sys_clk);
			n = 0;
			repeat (600) begin
				@(negedge sys_clk);
				if (pad_b !== (k != 0)) n = 1;
				if (pad_a !== 1'b1) n = 1;
			end
			@(posedge sys_clk);
			chk(n, 0, "constant level");
		end
		chk({30'h0, pin_a_oe, pin_b_oe}, 32'h3, "pins driven");
		bus(1'b1, `TPW_OFF_CTRL, 32'h000001c1);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({30'h0, pin_a_oe, pin_b_oe}, 32'h0, "pins released");
		@(posedge sys_clk);
		bus(1'b1, `TPW_OFF_CTRL, 32'h00003151);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({30'h0, pin_a_oe, pin_b_oe}, 32'h0, "toggle refused");
		@(posedge sys_clk);
		$display("Test pins done");
		bus(1'b1, `TPW_OFF_MASK, 32'h00000001);
		n = 0;
		while (irq !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 1000) stuck("interrupt");
		end
		@(posedge sys_clk);
		rd(`TPW_OFF_STAT, 32'h0000000f, "flags at interrupt");
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h00000000, "cleared by read");
		@(posedge sys_clk);
		bus(1'b1, `TPW_OFF_MASK, 32'h00000000);
		repeat (600) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h00000000, "masked");
		$display("Test interrupt done");
		tally_and_finish();
	end
endmodule

// ---- bench/tpw_load.sv ----
`timescale 1ns/10ps
module tpw_load (
	// Clock
	input wire logic sys_clk,
	// Pins from the block
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	input wire logic pin_b_out,
	input wire logic pin_b_oe,
	// Levels seen by the load
	output logic pad_a,
	output logic pad_b
);
	logic float_a_ff = 1'b0;
	logic float_b_ff = 1'b0;
	// Undriven pad wanders so a stale level never passes
	always_ff @(posedge sys_clk) begin
		float_a_ff <= ~pad_a;
		float_b_ff <= ~pad_b;
	end
	assign pad_a = pin_a_oe ? pin_a_out : float_a_ff;
	assign pad_b = pin_b_oe ? pin_b_out : float_b_ff;
endmodule

// ---- rtl/tpw_defs.svh ----
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH
`define TPW_OFF_CTRL 8'h00
`define TPW_OFF_CNT 8'h04
`define TPW_OFF_CMPA 8'h08
`define TPW_OFF_CMPB 8'h0c
`define TPW_OFF_CAPT 8'h10
`define TPW_OFF_STAT 8'h14
`define TPW_OFF_MASK 8'h18
`define TPW_CTRL_MODE 3:0
`define TPW_CTRL_COMA 5:4
`define TPW_CTRL_COMB 7:6
`define TPW_CTRL_CLK 10:8
`define TPW_CTRL_DIRA 12
`define TPW_CTRL_DIRB 13
`define TPW_CTRL_RST 16'h0000
`define TPW_WGM_PC8 4'h1
`define TPW_WGM_PC9 4'h2
`define TPW_WGM_PC10 4'h3
`define TPW_WGM_PFC_CAPT 4'h8
`define TPW_WGM_PFC_CMPA 4'h9
`define TPW_WGM_PC_CAPT 4'ha
`define TPW_WGM_PC_CMPA 4'hb
`define TPW_TOP8 16'h00ff
`define TPW_TOP9 16'h01ff
`define TPW_TOP10 16'h03ff
`define TPW_MAX 16'hffff
`define TPW_BOTTOM 16'h0000
`define TPW_CS_1 3'h1
`define TPW_CS_8 3'h2
`define TPW_CS_64 3'h3
`define TPW_CS_256 3'h4
`define TPW_CS_1024 3'h5
`define TPW_DIV1_M1 10'h000
`define TPW_DIV8_M1 10'h007
`define TPW_DIV64_M1 10'h03f
`define TPW_DIV256_M1 10'h0ff
`define TPW_DIV1024_M1 10'h3ff
`define TPW_ST_OVF 0
`define TPW_ST_CMPA 1
`define TPW_ST_CMPB 2
`define TPW_ST_CAPT 3
`endif

// ---- rtl/tpw_pkg.sv ----
package tpw_pkg;
	typedef logic [31:0] tpw_bus_t;
	typedef logic [15:0] tpw_word_t;
	typedef logic [3:0] tpw_mode_t;
	typedef logic [3:0] tpw_flags_t;
	typedef enum logic [1:0] {
		TPW_COM_OFF = 2'h0,
		TPW_COM_TGL = 2'h1,
		TPW_COM_NONINV = 2'h2,
		TPW_COM_INV = 2'h3
	} tpw_com_e;
endpackage

// ---- rtl/tpw_top.sv ----
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "tpw_defs.svh"
module tpw_top (
	// Clock and reset
	input logic sys_clk,
	input logic rst_n,
	// AHB-Lite slave
	input logic hsel,
	input tpw_pkg::tpw_bus_t haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic hready,
	input tpw_pkg::tpw_bus_t hwdata,
	output tpw_pkg::tpw_bus_t hrdata,
	output logic hreadyout,
	output logic hresp,
	// Compare pins
	output logic pin_a_out,
	output logic pin_a_oe,
	output logic pin_b_out,
	output logic pin_b_oe,
	// Interrupt
	output logic irq
);
	import tpw_pkg::*;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic dp_wr_ff;
	logic [7:0] dp_addr_ff;
	tpw_bus_t hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	tpw_word_t ctrl_ff;
	tpw_word_t cnt_ff;
	tpw_word_t capt_ff;
	tpw_word_t cmp_buf_ff [2];
	tpw_word_t cmp_act_ff [2];
	logic [1:0] oc_ff;
	logic [1:0] oe_ff;
	tpw_flags_t stat_ff;
	tpw_flags_t mask_ff;
	logic irq_ff;
	logic up_ff;
	logic [9:0] ps_ff;

	logic addr_ok;
	logic rd_stat;
	tpw_bus_t rd_data;
	logic wr_ctrl;
	logic wr_cnt;
	logic wr_capt;
	logic wr_mask;
	logic [1:0] wr_cmp;
	tpw_mode_t mode;
	tpw_com_e com [2];
	logic [1:0] dir;
	logic is_pc;
	logic is_pfc;
	logic run_dual;
	logic fixed_top;
	logic top_from_a;
	logic top_from_capt;
	tpw_word_t top_val;
	logic clk_on;
	logic [9:0] div_m1;
	logic tick;
	logic at_top;
	logic at_bot;
	logic rising;
	logic load_dual;
	logic [1:0] match;
	tpw_flags_t flag_set;

	// Bus address phase
	assign addr_ok = hsel && htrans[1] && hready;
	assign rd_stat = addr_ok && !hwrite
		&& haddr[7:0] == `TPW_OFF_STAT;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= 8'h00;
		end else begin
			dp_wr_ff <= addr_ok && hwrite;
			dp_addr_ff <= haddr[7:0];
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (haddr[7:0])
			`TPW_OFF_CTRL: rd_data = {16'h0000, ctrl_ff};
			`TPW_OFF_CNT: rd_data = {16'h0000, cnt_ff};
			`TPW_OFF_CMPA: rd_data = {16'h0000, cmp_buf_ff[0]};
			`TPW_OFF_CMPB: rd_data = {16'h0000, cmp_buf_ff[1]};
			`TPW_OFF_CAPT: rd_data = {16'h0000, capt_ff};
			`TPW_OFF_STAT: rd_data = {28'h000_0000, stat_ff};
			`TPW_OFF_MASK: rd_data = {28'h000_0000, mask_ff};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Read data launched for the data phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_ff <= 32'h0000_0000;
			hreadyout_ff <= 1'b0;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			if (addr_ok && !hwrite) begin
				hrdata_ff <= rd_data;
			end
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;

	// Data phase write strobes
	assign wr_ctrl = dp_wr_ff && dp_addr_ff == `TPW_OFF_CTRL;
	assign wr_cnt = dp_wr_ff && dp_addr_ff == `TPW_OFF_CNT;
	assign wr_capt = dp_wr_ff && dp_addr_ff == `TPW_OFF_CAPT;
	assign wr_mask = dp_wr_ff && dp_addr_ff == `TPW_OFF_MASK;
	assign wr_cmp[0] = dp_wr_ff && dp_addr_ff == `TPW_OFF_CMPA;
	assign wr_cmp[1] = dp_wr_ff && dp_addr_ff == `TPW_OFF_CMPB;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= `TPW_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_ff <= hwdata[15:0];
		end
	end

	// Capture register is not double buffered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			capt_ff <= `TPW_BOTTOM;
		end else if (wr_capt) begin
			capt_ff <= hwdata[15:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_ff <= 4'h0;
		end else if (wr_mask) begin
			mask_ff <= hwdata[3:0];
		end
	end

	// Mode decode
	assign mode = ctrl_ff[`TPW_CTRL_MODE];
	assign com[0] = tpw_com_e'(ctrl_ff[`TPW_CTRL_COMA]);
	assign com[1] = tpw_com_e'(ctrl_ff[`TPW_CTRL_COMB]);
	assign dir = {ctrl_ff[`TPW_CTRL_DIRB], ctrl_ff[`TPW_CTRL_DIRA]};
	assign fixed_top = mode == `TPW_WGM_PC8
		|| mode == `TPW_WGM_PC9 || mode == `TPW_WGM_PC10;
	assign is_pc = fixed_top || mode == `TPW_WGM_PC_CAPT
		|| mode == `TPW_WGM_PC_CMPA;
	assign is_pfc = mode == `TPW_WGM_PFC_CAPT
		|| mode == `TPW_WGM_PFC_CMPA;
	assign run_dual = is_pc || is_pfc;
	assign top_from_a = mode == `TPW_WGM_PC_CMPA
		|| mode == `TPW_WGM_PFC_CMPA;
	assign top_from_capt = mode == `TPW_WGM_PC_CAPT
		|| mode == `TPW_WGM_PFC_CAPT;

	always_comb begin
		case (mode)
			`TPW_WGM_PC8: top_val = `TPW_TOP8;
			`TPW_WGM_PC9: top_val = `TPW_TOP9;
			`TPW_WGM_PC10: top_val = `TPW_TOP10;
			`TPW_WGM_PC_CAPT: top_val = capt_ff;
			`TPW_WGM_PFC_CAPT: top_val = capt_ff;
			`TPW_WGM_PC_CMPA: top_val = cmp_act_ff[0];
			`TPW_WGM_PFC_CMPA: top_val = cmp_act_ff[0];
			default: top_val = `TPW_MAX;
		endcase
	end

	// Prescaler
	always_comb begin
		clk_on = 1'b1;
		case (ctrl_ff[`TPW_CTRL_CLK])
			`TPW_CS_1: div_m1 = `TPW_DIV1_M1;
			`TPW_CS_8: div_m1 = `TPW_DIV8_M1;
			`TPW_CS_64: div_m1 = `TPW_DIV64_M1;
			`TPW_CS_256: div_m1 = `TPW_DIV256_M1;
			`TPW_CS_1024: div_m1 = `TPW_DIV1024_M1;
			default: begin
				div_m1 = `TPW_DIV1_M1;
				clk_on = 1'b0;
			end
		endcase
	end

	assign tick = clk_on && ps_ff >= div_m1;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_ff <= 10'h000;
		end else if (!clk_on || tick) begin
			ps_ff <= 10'h000;
		end else begin
			ps_ff <= ps_ff + 10'h001;
		end
	end

	// Up/down counter
	assign at_top = cnt_ff == top_val;
	assign at_bot = cnt_ff == `TPW_BOTTOM;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= `TPW_BOTTOM;
		end else if (wr_cnt) begin
			cnt_ff <= hwdata[15:0];
		end else if (tick && run_dual) begin
			if (up_ff && at_top) begin
				cnt_ff <= cnt_ff - 16'h0001;
			end else if (!up_ff && at_bot) begin
				cnt_ff <= cnt_ff + 16'h0001;
			end else if (up_ff) begin
				cnt_ff <= cnt_ff + 16'h0001;
			end else begin
				cnt_ff <= cnt_ff - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_ff <= 1'b1;
		end else if (tick && run_dual && !wr_cnt) begin
			if (up_ff && at_top) begin
				up_ff <= 1'b0;
			end else if (!up_ff && at_bot) begin
				up_ff <= 1'b1;
			end
		end
	end

	AST_COUNT_UP: assert property (tick && run_dual && up_ff
		&& !at_top && !wr_cnt |=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("counter did not step up");
	AST_TOP_TURN: assert property (tick && run_dual && up_ff
		&& at_top && !wr_cnt && top_val != `TPW_BOTTOM
		|=> !up_ff && cnt_ff == $past(top_val) - 16'h0001)
		else $error("counter did not turn at top");
	AST_FIXED_TOP: assert property (tick && fixed_top && !wr_cnt
		&& cnt_ff <= top_val |=> cnt_ff <= $past(top_val))
		else $error("counter left fixed top range");
	AST_PC_DECODE: assert property (tick && at_top
		&& mode == `TPW_WGM_PC_CMPA
		|=> stat_ff[`TPW_ST_CMPA]
		&& cmp_act_ff[1] == $past(cmp_buf_ff[1]))
		else $error("mode 11 not phase correct");
	// A clock select write does not clear the prescaler; the check is off during it
	AST_TICK_8: assert property (disable iff (!rst_n || wr_ctrl)
		ctrl_ff[`TPW_CTRL_CLK] == `TPW_CS_8
		&& tick |=> !tick [*7] ##1 tick)
		else $error("divide by 8 tick spacing wrong");

	// Compare buffers and reload points
	assign load_dual = tick && ((is_pc && at_top)
		|| (is_pfc && at_bot));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				cmp_buf_ff[i] <= `TPW_BOTTOM;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_cmp[i] && fixed_top) begin
					cmp_buf_ff[i] <= hwdata[15:0] & top_val;
				end else if (wr_cmp[i]) begin
					cmp_buf_ff[i] <= hwdata[15:0];
				end
			end
		end
	end

	// Outside the dual-slope modes the compare follows its buffer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				cmp_act_ff[i] <= `TPW_BOTTOM;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!run_dual || load_dual) begin
					cmp_act_ff[i] <= cmp_buf_ff[i];
				end
			end
		end
	end

	AST_MASK_WR: assert property (wr_cmp[1] && fixed_top && !wr_ctrl
		|=> (cmp_buf_ff[1] & ~top_val) == `TPW_BOTTOM)
		else $error("upper compare bits not masked");
	AST_PC_LOAD: assert property (tick && is_pc && at_top
		|=> cmp_act_ff[0] == $past(cmp_buf_ff[0]))
		else $error("compare not reloaded at top");

	// Compare match and waveform; a match at bottom or top acts
	// as rising or falling so the extremes stay constant
	assign rising = at_bot ? 1'b1 : (at_top ? 1'b0 : up_ff);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			match[i] = tick && run_dual
				&& cnt_ff == cmp_act_ff[i];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_ff <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match[i] && com[i] == TPW_COM_NONINV) begin
					oc_ff[i] <= !rising;
				end else if (match[i] && com[i] == TPW_COM_INV) begin
					oc_ff[i] <= rising;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_ff <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				oe_ff[i] <= dir[i] && com[i] != TPW_COM_OFF
					&& com[i] != TPW_COM_TGL;
			end
		end
	end

	assign pin_a_out = oc_ff[0];
	assign pin_b_out = oc_ff[1];
	assign pin_a_oe = oe_ff[0];
	assign pin_b_oe = oe_ff[1];

	AST_NONINV_UP: assert property (match[1] && !at_bot && !at_top
		&& up_ff && com[1] == TPW_COM_NONINV |=> !oc_ff[1])
		else $error("non-inverted output not cleared on up match");
	AST_INV_DOWN: assert property (match[1] && !at_bot && !at_top
		&& !up_ff && com[1] == TPW_COM_INV |=> !oc_ff[1])
		else $error("inverted output not cleared on down match");
	AST_BOTTOM_LOW: assert property (match[1] && at_bot
		&& com[1] == TPW_COM_NONINV |=> !oc_ff[1])
		else $error("bottom compare did not drive low");
	AST_PIN_DIR: assert property (!dir[0] |=> !pin_a_oe)
		else $error("pin driven without direction bit");

	// Sticky flags; set wins over a read clear
	always_comb begin
		flag_set = 4'h0;
		flag_set[`TPW_ST_OVF] = tick && run_dual && at_bot;
		flag_set[`TPW_ST_CMPA] = match[0]
			|| (tick && top_from_a && at_top);
		flag_set[`TPW_ST_CMPB] = match[1];
		flag_set[`TPW_ST_CAPT] = tick
			&& top_from_capt && at_top;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_ff <= 4'h0;
		end else if (rd_stat) begin
			stat_ff <= flag_set;
		end else begin
			stat_ff <= stat_ff | flag_set;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	assign irq = irq_ff;

	AST_CMPB_FLAG: assert property (match[1]
		|=> stat_ff[`TPW_ST_CMPB])
		else $error("compare B flag not set");
	AST_OVF_BOT: assert property (tick && is_pc && at_bot
		|=> stat_ff[`TPW_ST_OVF])
		else $error("overflow flag not set at bottom");
	AST_PFC_LOAD: assert property (tick && is_pfc && at_bot
		|=> cmp_act_ff[1] == $past(cmp_buf_ff[1])
		&& stat_ff[`TPW_ST_OVF])
		else $error("bottom reload or overflow missing");
	AST_CAPT_TOP: assert property (tick && mode == `TPW_WGM_PFC_CAPT
		&& at_top |=> stat_ff[`TPW_ST_CAPT])
		else $error("capture flag not set at top");
	AST_IRQ: assert property ((stat_ff & mask_ff) != 4'h0
		|=> irq)
		else $error("interrupt not raised");

	COV_PC_TURN: cover property (tick && is_pc && up_ff && at_top);
	COV_PFC_LOAD: cover property (tick && is_pfc && at_bot);
	COV_PIN_TOGGLE: cover property (oe_ff[0] && oc_ff[0]
		##[1:1000] oe_ff[0] && !oc_ff[0]);
	COV_IRQ: cover property (!irq ##1 irq);
endmodule
